// File: wea_defs.svh
// Offsets, field positions, reset values and timing figures of the wake block
`ifndef WEA_DEFS_SVH
`define WEA_DEFS_SVH

// Register offsets in the runtime block
`define WEA_OFS_EDGE_SEL     8'h21
`define WEA_OFS_GBL_WAKE     8'h2F
`define WEA_OFS_STS_BASE     8'h30
`define WEA_OFS_EN_BASE      8'h38
`define WEA_OFS_SCAN_CODE    8'h5F
`define WEA_OFS_PM_LOW       8'h60
`define WEA_OFS_PM_HIGH      8'h61
`define WEA_OFS_MGMT_IRQ_STATUS_SEVEN     8'h64
`define WEA_OFS_MGMT_IRQ_ENABLE_SEVEN      8'h66
`define WEA_OFS_PIN_CTRL     8'h6E
`define WEA_OFS_KBC_CFG      8'h6F
`define WEA_OFS_CLK_CFG      8'hF0

// Field positions
`define WEA_BIT_SLEEP_EN     5
`define WEA_BIT_SMI_SLEEP    5
`define WEA_BIT_GBL_STS      0
`define WEA_BIT_GBL_EN       1
`define WEA_BIT_PIN_POL      1
`define WEA_BIT_PIN_OD       7
`define WEA_BIT_KBC_A_POL    0
`define WEA_BIT_EDGE_A       0
`define WEA_BIT_EDGE_B       1
`define WEA_BIT_CLK_EXT      0
`define WEA_BIT_KEY_DIS      1
`define WEA_G1_RING          0
`define WEA_G1_KBD           1
`define WEA_G1_MOUSE         2
`define WEA_G1_KBC_A         3
`define WEA_G1_KBC_B         4
`define WEA_G1_KEY           5
`define WEA_G1_WDT           6
`define WEA_G1_FAN           7

// Reset values
`define WEA_RST_ZERO         8'h00
`define WEA_RST_PIN_CTRL     8'h80

// Timing
`define WEA_REF_CLK_HZ       10000000
`define WEA_SLOW_CLK_HZ      32768
`define WEA_KEY_IDLE_TICKS   64
`define WEA_KEY_FRAME_BITS   11

`endif

// File: wea_pkg.sv
// Types shared by the wake event aggregator
package wea_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wea_reg_req_t;

	typedef enum logic [1:0] {
		KEY_OFF   = 2'b00,
		KEY_IDLE  = 2'b01,
		KEY_SHIFT = 2'b11,
		KEY_CHECK = 2'b10
	} wea_key_state_t;

	typedef struct packed {
		logic o;
		logic oe_n;
	} wea_pin_drive_t;

endpackage

// File: wea_wake_aggregator.sv
// Wake event aggregator with sleep-enable interrupt and specific-key detector
`include "wea_defs.svh"

module wea_wake_aggregator #(
	parameter int KEY_IDLE_TICKS = `WEA_KEY_IDLE_TICKS
) (
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire logic                 vtr_resetn,
	input  wire wea_pkg::wea_reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	input  wire logic                 ring_indicator_in,
	input  wire logic                 kbd_clk_in,
	input  wire logic                 kbd_data_in,
	input  wire logic                 mouse_data_in,
	input  wire logic                 ext_slow_clk_in,
	input  wire logic                 main_power_ok_in,
	input  wire logic                 kbc_port_event_a,
	input  wire logic                 kbc_port_event_b,
	input  wire logic                 wdt_timeout,
	input  wire logic                 fan_tach_event,
	input  wire logic [7:0]           dev_irq,
	input  wire logic [39:0]          gpio_in,
	input  wire logic [39:0]          gpio_polarity,
	input  wire logic [39:0]          either_edge_trigger,
	output logic                      wake_request_out_o,
	output logic                      wake_request_out_oe_n,
	output logic                      mgmt_irq_out
);

	localparam int SlowDiv = `WEA_REF_CLK_HZ / `WEA_SLOW_CLK_HZ;
	localparam logic [8:0] SLOW_DIV_M1 = 9'(SlowDiv - 1);
	localparam logic [7:0] IDLE_M1 = 8'(KEY_IDLE_TICKS - 1);
	localparam logic [3:0] LAST_BIT = 4'(`WEA_KEY_FRAME_BITS - 1);

	generate
		if (KEY_IDLE_TICKS < 2 || KEY_IDLE_TICKS > 255) begin : g_chk_idle
			$error("KEY_IDLE_TICKS must lie in 2..255");
		end
		if (SlowDiv < 2 || SlowDiv > 512) begin : g_chk_div
			$error("Slow clock divider out of range");
		end
	endgenerate

	// ==========================================================
	// Pin synchronisers
	localparam int PW = 46;
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] pin_s1_q;
	logic [PW-1:0] pin_s2_q;
	logic [PW-1:0] pin_prev_q;
	logic [PW-1:0] pin_prev;
	logic [2:0]    sync_fill_q;

	assign pin_raw = {gpio_in, ring_indicator_in, kbd_clk_in, kbd_data_in,
		mouse_data_in, ext_slow_clk_in, main_power_ok_in};

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_q   <= '1;
			pin_s2_q   <= '1;
			pin_prev_q  <= '1;
			sync_fill_q <= 3'h0;
		end else begin
			pin_s1_q    <= pin_raw;
			pin_s2_q    <= pin_s1_q;
			pin_prev_q  <= pin_s2_q;
			sync_fill_q <= {sync_fill_q[1:0], 1'b1};
		end
	end

	logic [39:0] gp_s;
	logic [39:0] gp_p;
	logic        ring_s;
	logic        ring_p;
	logic        kclk_s;
	logic        kdat_s;
	logic        kdat_p;
	logic        mdat_s;
	logic        mdat_p;
	logic        ext_s;
	logic        ext_p;
	logic        pwr_s;

	// No false edges while the stages still hold reset values
	assign pin_prev = sync_fill_q[2] ? pin_prev_q : pin_s2_q;

	assign gp_s   = pin_s2_q[45:6];
	assign gp_p   = pin_prev[45:6];
	assign ring_s = pin_s2_q[5];
	assign ring_p = pin_prev[5];
	assign kclk_s = pin_s2_q[4];
	assign kdat_s = pin_s2_q[3];
	assign kdat_p = pin_prev[3];
	assign mdat_s = pin_s2_q[2];
	assign mdat_p = pin_prev[2];
	assign ext_s  = pin_s2_q[1];
	assign ext_p  = pin_prev[1];
	assign pwr_s  = pin_s2_q[0];

	// ==========================================================
	// Register decode
	logic [7:0]      edge_sel_q;
	logic [7:0]      scan_q;
	logic [7:0]      pm_low_q;
	logic [7:0]      pm_high_q;
	logic            smi_sts_q;
	logic [7:0]      smi_en_q;
	logic [7:0]      pin_ctrl_q;
	logic [7:0]      kbc_cfg_q;
	logic [7:0]      clk_cfg_q;
	logic            gbl_sts_q;
	logic            gbl_en_q;
	logic [6:0][7:0] grp_sts_q;
	logic [6:0][7:0] grp_en_q;
	logic [6:0][7:0] grp_set;
	logic [6:0][7:0] grp_clr;
	logic            sleep_wr;
	logic            pending;

	function automatic logic hit(input logic [7:0] ofs);
		hit = reg_req.wr && (reg_req.addr == ofs);
	endfunction

	// A written one in sleep enable is the interrupt event
	assign sleep_wr = hit(`WEA_OFS_PM_HIGH) && reg_req.wdata[`WEA_BIT_SLEEP_EN];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			edge_sel_q <= `WEA_RST_ZERO;
			pm_low_q   <= `WEA_RST_ZERO;
			pm_high_q  <= `WEA_RST_ZERO;
			smi_en_q   <= `WEA_RST_ZERO;
			pin_ctrl_q <= `WEA_RST_PIN_CTRL;
			kbc_cfg_q  <= `WEA_RST_ZERO;
			clk_cfg_q  <= `WEA_RST_ZERO;
			gbl_en_q   <= 1'b0;
			grp_en_q   <= '0;
		end else begin
			if (hit(`WEA_OFS_EDGE_SEL))
				edge_sel_q <= reg_req.wdata;
			if (hit(`WEA_OFS_PM_LOW))
				pm_low_q <= reg_req.wdata;
			// Sleep enable is write-only, reads as zero
			if (hit(`WEA_OFS_PM_HIGH)) begin
				pm_high_q <= reg_req.wdata & 8'hDF;
			end
			if (hit(`WEA_OFS_MGMT_IRQ_ENABLE_SEVEN))
				smi_en_q <= reg_req.wdata;
			if (hit(`WEA_OFS_PIN_CTRL))
				pin_ctrl_q <= reg_req.wdata;
			if (hit(`WEA_OFS_KBC_CFG))
				kbc_cfg_q <= reg_req.wdata;
			if (hit(`WEA_OFS_CLK_CFG))
				clk_cfg_q <= reg_req.wdata;
			if (hit(`WEA_OFS_GBL_WAKE))
				gbl_en_q <= reg_req.wdata[`WEA_BIT_GBL_EN];
			for (int g = 0; g < 7; g++) begin
				if (hit(`WEA_OFS_EN_BASE + 8'(g)))
					grp_en_q[g] <= reg_req.wdata;
			end
		end
	end

	// Scan code lives on standby power
	always_ff @(posedge ref_clk or negedge vtr_resetn) begin
		if (!vtr_resetn)
			scan_q <= `WEA_RST_ZERO;
		else if (hit(`WEA_OFS_SCAN_CODE))
			scan_q <= reg_req.wdata;
	end

	// Sleep interrupt status: set wins over write-one clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			smi_sts_q    <= 1'b0;
			mgmt_irq_out <= 1'b0;
		end else begin
			smi_sts_q <= sleep_wr || (smi_sts_q && !(hit(`WEA_OFS_MGMT_IRQ_STATUS_SEVEN)
				&& reg_req.wdata[`WEA_BIT_SMI_SLEEP]));
			mgmt_irq_out <= smi_sts_q && smi_en_q[`WEA_BIT_SMI_SLEEP];
		end
	end

	// ==========================================================
	// Wake sources
	logic [39:0] gp_rise;
	logic [39:0] gp_fall;
	logic [39:0] gp_evt;
	logic [3:0]  misc_prev_q;
	logic        kbc_a_lvl;
	logic [1:0]  kbc_rise;
	logic [1:0]  kbc_fall;
	logic [1:0]  kbc_evt;
	logic        key_match;

	assign gp_rise = gp_s & ~gp_p;
	assign gp_fall = ~gp_s & gp_p;
	assign gp_evt = (either_edge_trigger & (gp_rise | gp_fall))
		| (~either_edge_trigger & ~gpio_polarity & gp_rise)
		| (~either_edge_trigger & gpio_polarity & gp_fall);

	assign kbc_a_lvl = kbc_port_event_a ^ kbc_cfg_q[`WEA_BIT_KBC_A_POL];
	assign kbc_rise  = {kbc_port_event_b, kbc_a_lvl} & ~misc_prev_q[1:0];
	assign kbc_fall  = ~{kbc_port_event_b, kbc_a_lvl} & misc_prev_q[1:0];
	// Falling edge, or both edges when selected
	assign kbc_evt[0] = kbc_fall[0] | (edge_sel_q[`WEA_BIT_EDGE_A] & kbc_rise[0]);
	assign kbc_evt[1] = kbc_fall[1] | (edge_sel_q[`WEA_BIT_EDGE_B] & kbc_rise[1]);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			misc_prev_q <= 4'h0;
		else
			misc_prev_q <= {fan_tach_event, wdt_timeout, kbc_port_event_b, kbc_a_lvl};
	end

	always_comb begin
		grp_set = '0;
		grp_set[0][`WEA_G1_RING]  = ring_p & ~ring_s;
		grp_set[0][`WEA_G1_KBD]   = kdat_p & ~kdat_s;
		grp_set[0][`WEA_G1_MOUSE] = mdat_p & ~mdat_s;
		grp_set[0][`WEA_G1_KBC_A] = kbc_evt[0];
		grp_set[0][`WEA_G1_KBC_B] = kbc_evt[1];
		grp_set[0][`WEA_G1_KEY]   = key_match;
		grp_set[0][`WEA_G1_WDT]   = wdt_timeout & ~misc_prev_q[2];
		grp_set[0][`WEA_G1_FAN]   = fan_tach_event & ~misc_prev_q[3];
		grp_set[1] = gp_evt[7:0];
		grp_set[2] = gp_evt[15:8];
		grp_set[3] = gp_evt[23:16];
		grp_set[4] = gp_evt[31:24];
		grp_set[6] = gp_evt[39:32];
		for (int g = 0; g < 7; g++) begin
			grp_clr[g] = hit(`WEA_OFS_STS_BASE + 8'(g)) ? reg_req.wdata : 8'h00;
		end
	end

	// Status: write-one clear, set wins; group 6 follows the irq level
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			grp_sts_q <= '0;
		end else begin
			for (int g = 0; g < 7; g++) begin
				if (g == 5)
					grp_sts_q[g] <= dev_irq;
				else
					grp_sts_q[g] <= (grp_sts_q[g] & ~grp_clr[g])
						| grp_set[g];
			end
		end
	end

	// ==========================================================
	// Global status and wake pin
	assign pending = |(grp_sts_q & grp_en_q);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			gbl_sts_q <= 1'b0;
		else
			gbl_sts_q <= pending || (gbl_sts_q && !(hit(`WEA_OFS_GBL_WAKE)
				&& reg_req.wdata[`WEA_BIT_GBL_STS]));
	end

	wea_pkg::wea_pin_drive_t pin_d;
	logic wake_active;
	logic wake_level;

	assign wake_active = gbl_en_q & pending;
	assign wake_level  = pin_ctrl_q[`WEA_BIT_PIN_POL] ? wake_active : ~wake_active;

	always_comb begin
		if (pin_ctrl_q[`WEA_BIT_PIN_OD]) begin
			pin_d.o    = 1'b0;
			pin_d.oe_n = wake_level;
		end else begin
			pin_d.o    = wake_level;
			pin_d.oe_n = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wake_request_out_o    <= 1'b0;
			wake_request_out_oe_n <= 1'b1;
		end else begin
			wake_request_out_o    <= pin_d.o;
			wake_request_out_oe_n <= pin_d.oe_n;
		end
	end

	// ==========================================================
	// Register read
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (reg_req.addr)
			`WEA_OFS_EDGE_SEL:  rd_mux = edge_sel_q;
			`WEA_OFS_SCAN_CODE: rd_mux = scan_q;
			`WEA_OFS_PM_LOW:    rd_mux = pm_low_q;
			`WEA_OFS_PM_HIGH:   rd_mux = pm_high_q;
			`WEA_OFS_MGMT_IRQ_STATUS_SEVEN:  rd_mux = {2'b00, smi_sts_q, 5'h00};
			`WEA_OFS_MGMT_IRQ_ENABLE_SEVEN:   rd_mux = smi_en_q;
			`WEA_OFS_PIN_CTRL:  rd_mux = pin_ctrl_q;
			`WEA_OFS_KBC_CFG:   rd_mux = kbc_cfg_q;
			`WEA_OFS_CLK_CFG:   rd_mux = clk_cfg_q;
			`WEA_OFS_GBL_WAKE:  rd_mux = {6'h00, gbl_en_q, gbl_sts_q};
			default: begin
				for (int g = 0; g < 7; g++) begin
					if (reg_req.addr == `WEA_OFS_STS_BASE + 8'(g))
						rd_mux = grp_sts_q[g];
					if (reg_req.addr == `WEA_OFS_EN_BASE + 8'(g))
						rd_mux = grp_en_q[g];
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_req.rd)
			reg_rdata <= rd_mux;
	end

	// ==========================================================
	// Specific-key detector
	wea_pkg::wea_key_state_t key_st_q;
	logic [8:0]  div_q;
	logic        int_tick;
	logic        key_on;
	logic        key_tick;
	logic        kclk_prev_q;
	logic        kfall;
	logic [10:0] frame_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  gap_q;

	assign int_tick = (div_q == SLOW_DIV_M1);
	assign key_on   = ~clk_cfg_q[`WEA_BIT_KEY_DIS];
	assign key_tick = key_on & (clk_cfg_q[`WEA_BIT_CLK_EXT] ? (ext_s & ~ext_p)
		: (int_tick & pwr_s));
	assign kfall = key_tick & kclk_prev_q & ~kclk_s;
	// Start 0, stop 1, odd parity, data equals code
	assign key_match = (key_st_q == wea_pkg::KEY_CHECK) & ~frame_q[0]
		& frame_q[10] & (^frame_q[9:1]) & (frame_q[8:1] == scan_q);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			div_q <= 9'h000;
		else if (int_tick)
			div_q <= 9'h000;
		else
			div_q <= div_q + 9'h001;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			key_st_q    <= wea_pkg::KEY_OFF;
			kclk_prev_q <= 1'b1;
			frame_q     <= 11'h000;
			bit_cnt_q   <= 4'h0;
			gap_q       <= 8'h00;
		end else begin
			if (key_tick)
				kclk_prev_q <= kclk_s;
			if (kfall)
				frame_q <= {kdat_s, frame_q[10:1]};
			case (key_st_q)
				wea_pkg::KEY_OFF: begin
					if (key_on)
						key_st_q <= wea_pkg::KEY_IDLE;
				end
				wea_pkg::KEY_IDLE: begin
					if (!key_on) begin
						key_st_q <= wea_pkg::KEY_OFF;
					end else if (kfall) begin
						key_st_q  <= wea_pkg::KEY_SHIFT;
						bit_cnt_q <= 4'h1;
						gap_q     <= 8'h00;
					end
				end
				wea_pkg::KEY_SHIFT: begin
					if (!key_on) begin
						key_st_q <= wea_pkg::KEY_OFF;
					end else if (kfall) begin
						gap_q     <= 8'h00;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == LAST_BIT)
							key_st_q <= wea_pkg::KEY_CHECK;
					end else if (key_tick) begin
						// Drop a broken frame after a long quiet gap
						if (gap_q == IDLE_M1)
							key_st_q <= wea_pkg::KEY_IDLE;
						gap_q <= gap_q + 8'h01;
					end
				end
				wea_pkg::KEY_CHECK: begin
					key_st_q <= key_on ? wea_pkg::KEY_IDLE : wea_pkg::KEY_OFF;
				end
				default: begin
					key_st_q <= wea_pkg::KEY_OFF;
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_wake_gated_off: assert property (
		!gbl_en_q && pin_ctrl_q == `WEA_RST_PIN_CTRL |=> wake_request_out_oe_n)
		else $error("wake driven while global enable clear");
	a_wake_enabled_on: assert property (
		gbl_en_q && pending && pin_ctrl_q == `WEA_RST_PIN_CTRL
		|=> !wake_request_out_oe_n && !wake_request_out_o)
		else $error("enabled pending source did not drive wake");
	a_sleep_smi_raise: assert property (
		sleep_wr && smi_en_q[`WEA_BIT_SMI_SLEEP] && !hit(`WEA_OFS_MGMT_IRQ_ENABLE_SEVEN)
		|=> ##1 mgmt_irq_out)
		else $error("sleep enable write raised no interrupt");
	a_sleep_type_rw: assert property (
		hit(`WEA_OFS_PM_HIGH) |=> pm_high_q[4:2] == $past(reg_req.wdata[4:2]))
		else $error("sleep type field not stored");
	a_gsts_set_always: assert property (
		pending |=> gbl_sts_q)
		else $error("global status missed pending event");
	a_gsts_holds: assert property (
		gbl_sts_q && pending |=> gbl_sts_q)
		else $error("global status cleared with events pending");
	// Groups 2, 3, 4, 5 and 7 hold GPIO status
	localparam logic [55:0] GPIO_GRP_MASK = 56'hFF00_FFFF_FFFF_00;

	a_gpio_clear_one: assert property (
		(~grp_sts_q & $past(grp_sts_q) & ~$past(grp_clr)
		& GPIO_GRP_MASK) == '0)
		else $error("GPIO status fell without a written one");
	a_kbc_clear_drop: assert property (
		hit(`WEA_OFS_STS_BASE) && reg_req.wdata[`WEA_G1_KBC_B] && !kbc_evt[1]
		|=> !grp_sts_q[0][`WEA_G1_KBC_B])
		else $error("port event B status not cleared");
	a_key_match_sets: assert property (
		key_match |=> grp_sts_q[0][`WEA_G1_KEY])
		else $error("key match did not set status");
	a_key_off_gate: assert property (
		clk_cfg_q[`WEA_BIT_KEY_DIS] |-> !key_tick ##1 key_st_q == wea_pkg::KEY_OFF)
		else $error("disabled key logic still clocked");

	c_sleep_smi: cover property (sleep_wr ##2 mgmt_irq_out);
	c_key_match: cover property (key_match);
	c_wake_pin: cover property ($fell(wake_request_out_oe_n));

endmodule

// File: wea_chipset_model.sv
// Chipset-side model: wake line pull-up and keyboard frame sender
module wea_chipset_model (
	input  wire logic ref_clk,
	input  wire logic wake_o,
	input  wire logic wake_oe_n,
	output logic      wake_line,
	output logic      kbd_clk,
	output logic      kbd_data
);
	timeunit 1ns;
	timeprecision 1ns;

	// Released open-drain line floats to the pull-up
	assign wake_line = wake_oe_n ? 1'b1 : wake_o;

	initial begin
		kbd_clk = 1'b1;
		kbd_data = 1'b1;
	end

	// Start, data LSB first, odd parity, stop; clock idles high
	task automatic send_key(input logic [7:0] code);
		logic [10:0] frame;
		frame = {1'b1, ~^code, code, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge ref_clk);
			kbd_data = frame[i];
			repeat (900) @(negedge ref_clk);
			kbd_clk = 1'b0;
			repeat (900) @(negedge ref_clk);
			kbd_clk = 1'b1;
		end
	endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the wake event aggregator
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  ref_clk, resetn, vtr_resetn;
	wea_pkg::wea_reg_req_t reg_req;
	logic [7:0]            reg_rdata, dev_irq, rnd, a;
	logic                  ring_n, mouse, kbc_b, wdt, fan, rd_seen;
	logic                  kbc_a, pwr, ext_clk;
	logic [39:0]           gpio, gpio_pol, eet;
	logic                  wake_o, wake_oe_n, mgmt_irq;
	logic                  wake_line, kbd_clk, kbd_data;
	logic [7:0]            exp_q[$];
	logic [3:0]            cs[6];
	logic [31:0]           seed;
	int                    mismatches, cmp_count, cycles, idx, g;

	wea_wake_aggregator #(.KEY_IDLE_TICKS(16)) wea_wake_aggregator_inst (
		.ref_clk(ref_clk), .resetn(resetn), .vtr_resetn(vtr_resetn),
		.reg_req(reg_req), .reg_rdata(reg_rdata),
		.ring_indicator_in(ring_n), .kbd_clk_in(kbd_clk),
		.kbd_data_in(kbd_data), .mouse_data_in(mouse),
		.ext_slow_clk_in(ext_clk), .main_power_ok_in(pwr),
		.kbc_port_event_a(kbc_a), .kbc_port_event_b(kbc_b),
		.wdt_timeout(wdt), .fan_tach_event(fan), .dev_irq(dev_irq),
		.gpio_in(gpio), .gpio_polarity(gpio_pol),
		.either_edge_trigger(eet), .wake_request_out_o(wake_o),
		.wake_request_out_oe_n(wake_oe_n), .mgmt_irq_out(mgmt_irq)
	);

	wea_chipset_model wea_chipset_model_inst (
		.ref_clk(ref_clk), .wake_o(wake_o), .wake_oe_n(wake_oe_n),
		.wake_line(wake_line), .kbd_clk(kbd_clk), .kbd_data(kbd_data)
	);

	// ==========================================
	// Clock, helpers
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	// Free-running external slow clock, 300 cycles a period
	always @(negedge ref_clk) begin
		if (cycles % 150 == 0)
			ext_clk = ~ext_clk;
	end

	function automatic logic [7:0] next();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge ref_clk);
		reg_req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		@(negedge ref_clk);
		exp_q.push_back(e);
		reg_req = '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge ref_clk);
		reg_req.rd = 1'b0;
	endtask

	task automatic pin(input logic l, input logic i);
		check({6'h00, wake_line, mgmt_irq}, {6'h00, l, i});
	endtask

	task automatic settle();
		repeat (6) @(negedge ref_clk);
	endtask

	// Read data watcher: oldest expectation per read
	always @(posedge ref_clk) rd_seen <= reg_req.rd;
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			check(reg_rdata, exp_q.pop_front());
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 80000) begin
			mismatches++;
			results();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		seed = 32'h5551;
		cs = '{4'b0011, 4'b0000, 4'b1001, 4'b1010, 4'b0101, 4'b0111};
		{resetn, vtr_resetn, rd_seen} = 3'b000;
		reg_req = '0;
		{ring_n, mouse, kbc_b, wdt, fan} = 5'b11000;
		{kbc_a, pwr, ext_clk} = 3'b010;
		{dev_irq, gpio, gpio_pol, eet} = '0;
		{mismatches, cmp_count, cycles} = '0;
		repeat (5) @(negedge ref_clk);
		{resetn, vtr_resetn} = 2'b11;
		rd(8'h6E, 8'h80);
		pin(1'b1, 1'b0);
		rd(8'h7F, 8'h00);
		wr(8'h66, 8'h20);
		rnd = next() & 8'h1C;
		wr(8'h61, rnd | 8'h20);
		repeat (2) @(negedge ref_clk);
		pin(1'b1, 1'b1);
		rd(8'h64, 8'h20);
		rd(8'h61, rnd);
		wr(8'h60, ~rnd);
		rd(8'h60, ~rnd);
		wr(8'h64, 8'h20);
		wr(8'h61, 8'h1C);
		settle();
		pin(1'b1, 1'b0);
		{ring_n, mouse, wdt} = 3'b001;
		dev_irq = next();
		settle();
		rd(8'h30, 8'h45);
		rd(8'h35, dev_irq);
		rd(8'h2F, 8'h00);
		{ring_n, mouse} = 2'b11;
		wr(8'h30, 8'hFF);
		wr(8'h38, 8'h80);
		fan = 1'b1;
		settle();
		pin(1'b1, 1'b0);
		rd(8'h2F, 8'h01);
		wr(8'h2F, 8'h02);
		settle();
		pin(1'b0, 1'b0);
		wr(8'h2F, 8'h03);
		rd(8'h2F, 8'h03);
		wr(8'h30, 8'h80);
		wr(8'h2F, 8'h03);
		settle();
		rd(8'h2F, 8'h02);
		pin(1'b1, 1'b0);
		for (int c = 0; c < 6; c++) begin
			idx = int'(next()) % 40;
			g = idx / 8;
			a = 8'h31 + ((g == 4) ? 8'h05 : 8'(g));
			gpio_pol[idx] = cs[c][3];
			eet[idx] = cs[c][2];
			gpio[idx] = ~cs[c][1];
			settle();
			wr(a, 8'hFF);
			gpio[idx] = cs[c][1];
			settle();
			rd(a, cs[c][0] ? 8'h01 << (idx % 8) : 8'h00);
			wr(a, 8'h00);
			rd(a, cs[c][0] ? 8'h01 << (idx % 8) : 8'h00);
			wr(a, 8'hFF);
		end
		kbc_b = 1'b1;
		settle();
		rd(8'h30, 8'h00);
		kbc_b = 1'b0;
		settle();
		rd(8'h30, 8'h10);
		wr(8'h38, 8'h10);
		settle();
		pin(1'b0, 1'b0);
		wr(8'h6E, 8'h02);
		repeat (2) @(negedge ref_clk);
		check({6'h00, wake_oe_n, wake_o}, 8'h01);
		wr(8'h6E, 8'h80);
		wr(8'h30, 8'h10);
		repeat (2) @(negedge ref_clk);
		pin(1'b1, 1'b0);
		wr(8'h6F, 8'h01);
		rd(8'h6F, 8'h01);
		kbc_a = 1'b1;
		settle();
		rd(8'h30, 8'h08);
		wr(8'h21, 8'h03);
		rd(8'h21, 8'h03);
		kbc_b = 1'b1;
		settle();
		pin(1'b0, 1'b0);
		wr(8'h30, 8'h10);
		kbc_b = 1'b0;
		settle();
		pin(1'b0, 1'b0);
		wr(8'h30, 8'hFF);
		rnd = next();
		wr(8'h5F, rnd);
		wea_chipset_model_inst.send_key(rnd);
		settle();
		rd(8'h30, 8'h22);
		pin(1'b1, 1'b0);
		wr(8'h38, 8'h20);
		repeat (2) @(negedge ref_clk);
		pin(1'b0, 1'b0);
		wr(8'h30, 8'hFF);
		wr(8'hF0, 8'h02);
		rd(8'hF0, 8'h02);
		wea_chipset_model_inst.send_key(rnd);
		settle();
		rd(8'h30, 8'h02);
		wr(8'h30, 8'hFF);
		pwr = 1'b0;
		wr(8'hF0, 8'h01);
		rd(8'hF0, 8'h01);
		wea_chipset_model_inst.send_key(rnd);
		settle();
		rd(8'h30, 8'h22);
		resetn = 1'b0;
		@(negedge ref_clk);
		resetn = 1'b1;
		rd(8'h5F, rnd);
		vtr_resetn = 1'b0;
		@(negedge ref_clk);
		vtr_resetn = 1'b1;
		rd(8'h5F, 8'h00);
		settle();
		results();
	end
endmodule
